//--- wwd_watchdog.sv
// Purpose: Window watchdog with a 7-bit down counter behind a Wishbone slave
// Assumes: Inputs synchronous to mclk; system reset drives reset_n
// Notes:   Reset request is sticky until reset_n falls
// What this block and the software driving it do
// RULE_01: Seven-bit down counter steps once per prescaled count tick.
// RULE_02: Tick divides bus clock by 4096 times two to the select, up to 524288.
// RULE_03: Counting halts in deep sleep and resumes after wake-up.
// RULE_04: Enable at bit 7, counter at bits 6:0 of control count, reset 0x7F.
// RULE_05: Off after reset, started by writing 1, never stopped by software.
// RULE_06: Reading the counter field gives the live count; writing loads it.
// RULE_07: Once enabled, counts down from the last loaded value.
// RULE_08: Reaching 0x40 sets the pre-overflow flag.
// RULE_09: Interrupt is flag and enable; enable cannot be cleared once set.
// RULE_10: Reaching 0x3F requests a system reset.
// RULE_11: Reloading while count is above window requests a system reset.
// RULE_12: Loading 0x3F or below requests a system reset.
// RULE_13: Software sets window below start count and configures before enabling.
// RULE_14: Software refreshes only at or below window and above 0x3F.
// RULE_15: Software opens the bus clock gate before any configuration.
// RULE_16: Registers sit at 0x00, 0x04 and 0x08.
// RULE_17: Prescale select lives in bits 9:7 of control config.
// RULE_18: Interrupt enable lives at bit 10 of control config.
// RULE_19: Pre-overflow flag at status bit 0, cleared by writing 0.
// RULE_20: Window value in config bits 6:0, compared with the live count.
//
// Chosen here: register access over Wishbone.
`include "wwd_map.svh"
`timescale 1ns/10ps
`default_nettype none

module wwd_watchdog #(
    parameter int unsigned BASE_DIV_LOG2 = `WWD_DIV_BASE_LOG2
) (
    input  wire logic                 mclk,             // Bus clock, 25 MHz
    input  wire logic                 reset_n,          // Async reset, active low
    input  wire wwd_pkg::wwd_wb_req_s wb_req,           // Wishbone request bundle
    output logic [31:0]               wb_dat_o,         // Wishbone read data
    output logic                      wb_ack_o,         // Wishbone acknowledge
    input  wire logic                 deep_sleep,       // Deep sleep state
    output logic                      pre_overflow_irq, // Pre-overflow request
    output logic                      sys_reset_req     // System reset request
);

    wwd_pkg::wwd_state_s st;
    wwd_pkg::wwd_state_s next_st;

    logic        tick;
    logic        run;
    logic        access;
    logic        wr;
    logic        rd;
    logic        hit_count;
    logic        hit_config;
    logic        hit_status;
    logic        wr_cnt;
    logic [31:0] read_word;

    // Bus decode; a request is taken once, the ack cycle masks a repeat
    assign access     = wb_req.cyc && wb_req.stb && !st.ack;
    assign wr         = access && wb_req.we;
    assign rd         = access && !wb_req.we;
    assign hit_count  = wb_req.adr == `WWD_OFF_CTRL_COUNT;   // see RULE_16
    assign hit_config = wb_req.adr == `WWD_OFF_CTRL_CONFIG;  // see RULE_16
    assign hit_status = wb_req.adr == `WWD_OFF_STATUS;       // see RULE_16
    assign wr_cnt     = wr && hit_count && wb_req.sel[0];

    // Counting stops once a reset is asked for, so the count stays visible
    assign run = st.en && !deep_sleep && !st.rst_req; // see RULE_03

    wwd_prescaler #(
        .BASE_LOG2 (BASE_DIV_LOG2)
    ) u_prescaler (
        .mclk    (mclk),
        .reset_n (reset_n),
        .run     (run),
        .sel     (st.prescale_select),
        .tick    (tick)
    );

    // Read data mux; unmapped offsets read as zero
    always_comb begin
        read_word = 32'h00000000;
        if (hit_count) begin
            read_word[`WWD_EN_BIT]               = st.en;
            read_word[`WWD_CNT_MSB:`WWD_CNT_LSB] = st.cnt;  // see RULE_06
        end else if (hit_config) begin
            read_word[`WWD_WIN_MSB:`WWD_WIN_LSB] = st.win;
            read_word[`WWD_PRS_MSB:`WWD_PRS_LSB] = st.prescale_select;
            read_word[`WWD_IE_BIT]               = st.ie;
        end else if (hit_status) begin
            read_word[`WWD_POV_BIT] = st.pre_overflow_flag;
        end
    end

    always_comb begin
        next_st     = st;
        next_st.ack = 1'b0;

        if (access) begin
            next_st.ack = 1'b1;
        end
        if (rd) begin
            next_st.rdata = read_word;
        end

        // Control count writes
        if (wr && hit_count && wb_req.sel[0]) begin
            // Writing 0 is ignored; only a system reset turns it off
            if (wb_req.dat[`WWD_EN_BIT]) begin
                next_st.en = 1'b1; // see RULE_05
            end
            // Early refresh: count still above the window
            if (st.en && st.cnt > st.win) begin
                next_st.rst_req = 1'b1; // see RULE_11, RULE_20
            end
            if (wb_req.dat[`WWD_CNT_MSB:`WWD_CNT_LSB] <= `WWD_CNT_UNDERFLOW) begin
                next_st.rst_req = 1'b1; // see RULE_12
            end
            next_st.cnt = wb_req.dat[`WWD_CNT_MSB:`WWD_CNT_LSB]; // see RULE_06, RULE_07
        end

        // Control config writes, byte lanes 0 and 1
        if (wr && hit_config) begin
            if (wb_req.sel[0]) begin
                next_st.win    = wb_req.dat[`WWD_WIN_MSB:`WWD_WIN_LSB]; // see RULE_20
                next_st.prescale_select[0] = wb_req.dat[`WWD_PRS_LSB];              // see RULE_17
            end
            if (wb_req.sel[1]) begin
                next_st.prescale_select[2:1] = wb_req.dat[`WWD_PRS_MSB:`WWD_PRS_LSB+1]; // see RULE_17
                // Enable can be set but never cleared
                if (wb_req.dat[`WWD_IE_BIT]) begin
                    next_st.ie = 1'b1; // see RULE_09, RULE_18
                end
            end
        end

        // Status write: 0 clears the flag, 1 leaves it
        if (wr && hit_status && wb_req.sel[0] && !wb_req.dat[`WWD_POV_BIT]) begin
            next_st.pre_overflow_flag = 1'b0; // see RULE_19
        end

        // Count step; a load in the same cycle wins over the tick
        if (tick && !wr_cnt) begin
            next_st.cnt = st.cnt - `WWD_CNT_ONE; // see RULE_01, RULE_07
            // Set after the clear so a same-cycle event is kept
            if (next_st.cnt == `WWD_CNT_PREWARN) begin
                next_st.pre_overflow_flag = 1'b1; // see RULE_08
            end
            if (next_st.cnt == `WWD_CNT_UNDERFLOW) begin
                next_st.rst_req = 1'b1; // see RULE_10
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st.en      <= 1'b0;          // see RULE_05
            st.cnt     <= `WWD_RST_CNT;  // see RULE_04
            st.win     <= `WWD_RST_WIN;
            st.prescale_select     <= `WWD_RST_PRS;
            st.ie      <= 1'b0;
            st.pre_overflow_flag     <= 1'b0;
            st.rst_req <= 1'b0;
            st.ack     <= 1'b0;
            st.rdata   <= 32'h00000000;
        end else begin
            st <= next_st;
        end
    end

    assign wb_dat_o         = st.rdata;
    assign wb_ack_o         = st.ack;
    assign pre_overflow_irq = st.pre_overflow_flag && st.ie; // see RULE_09
    assign sys_reset_req    = st.rst_req;

    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    sequence s_tick_step;
        tick && !wr_cnt;
    endsequence

    sequence s_bus_read(logic hit);
        rd && hit;
    endsequence

    sequence s_count_write;
        wr_cnt;
    endsequence

    sequence s_config_write;
        wr && hit_config;
    endsequence

    // Two sampled cycles of sleep, so a tick already in flight has landed
    sequence s_asleep;
        deep_sleep ##1 deep_sleep;
    endsequence

    property p_step_value;
        logic [6:0] c;
        (s_tick_step, c = st.cnt) |=> st.cnt == c - `WWD_CNT_ONE;
    endproperty

    a_count_step: assert property (p_step_value) // see RULE_01
        else $error("Counter did not step down by one on tick");

    a_sleep_halt: assert property ( // see RULE_03
        deep_sleep |=> !tick)
        else $error("Tick arrived during deep sleep");

    a_enable_sticky: assert property ( // see RULE_05
        st.en |=> st.en)
        else $error("Watchdog enable was cleared");

    a_idle_frozen: assert property ( // see RULE_07
        !st.en && !wr_cnt |=> $stable(st.cnt))
        else $error("Counter moved while disabled");

    a_read_count: assert property ( // see RULE_06
        s_bus_read(hit_count) |=> wb_ack_o && wb_dat_o[6:0] == $past(st.cnt))
        else $error("Count read did not return live count");

    a_status_read: assert property ( // see RULE_16
        s_bus_read(hit_status) |=> wb_dat_o[31:1] == 31'h00000000)
        else $error("Status reserved bits read nonzero");

    a_pov_raise: assert property ( // see RULE_08
        s_tick_step ##0 st.cnt == `WWD_CNT_PREWARN + `WWD_CNT_ONE |=> st.pre_overflow_flag)
        else $error("Pre-overflow flag not set at 0x40");

    a_irq_follow: assert property ( // see RULE_09
        $rose(st.pre_overflow_flag) && st.ie |-> pre_overflow_irq)
        else $error("Interrupt missing with flag and enable");

    a_ie_sticky: assert property ( // see RULE_09
        st.ie |=> st.ie)
        else $error("Interrupt enable was cleared");

    a_underflow_reset: assert property ( // see RULE_10
        s_tick_step ##0 st.cnt == `WWD_CNT_PREWARN |=> sys_reset_req [*2])
        else $error("No reset request on reaching 0x3F");

    a_early_refresh: assert property ( // see RULE_11
        wr_cnt && st.en && st.cnt > st.win |=> sys_reset_req)
        else $error("Early refresh did not request reset");

    a_low_load: assert property ( // see RULE_12
        wr_cnt && wb_req.dat[6:0] <= `WWD_CNT_UNDERFLOW |=> sys_reset_req)
        else $error("Low load did not request reset");

    a_pov_clear: assert property ( // see RULE_19
        wr && hit_status && wb_req.sel[0] && !wb_req.dat[0] && !tick |=> !st.pre_overflow_flag)
        else $error("Flag not cleared by writing 0");

    a_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("Ack held longer than one cycle");

    a_ack_source: assert property (
        wb_ack_o |-> $past(access))
        else $error("Ack without a request");

    a_rdata_hold: assert property (
        !rd |=> $stable(wb_dat_o))
        else $error("Read data moved without a read");

    a_count_load: assert property ( // see RULE_06
        s_count_write |=> st.cnt == $past(wb_req.dat[`WWD_CNT_MSB:`WWD_CNT_LSB]))
        else $error("Written count was not loaded");

    a_enable_set: assert property ( // see RULE_05
        s_count_write ##0 wb_req.dat[`WWD_EN_BIT] |=> st.en)
        else $error("Writing 1 to enable did not start the watchdog");

    a_idle_no_tick: assert property ( // see RULE_05
        !st.en |-> !tick)
        else $error("Tick while the watchdog is off");

    a_tick_needs_run: assert property ( // see RULE_03
        tick |-> $past(run))
        else $error("Tick without a running prescaler");

    a_sleep_freeze: assert property ( // see RULE_03
        s_asleep ##0 !wr_cnt |=> $stable(st.cnt))
        else $error("Counter moved in deep sleep");

    a_reset_sticky: assert property ( // see RULE_10
        sys_reset_req |=> sys_reset_req)
        else $error("Reset request dropped before system reset");

    a_halt_after_req: assert property ( // see RULE_10
        sys_reset_req |=> !tick)
        else $error("Counting went on after a reset request");

    // Guards against a reset request with no cause behind it
    a_reset_cause: assert property ( // see RULE_10
        $rose(sys_reset_req) |-> $past(wr_cnt) || st.cnt == `WWD_CNT_UNDERFLOW)
        else $error("Reset request without a cause");

    a_refresh_ok: assert property ( // see RULE_11
        wr_cnt && st.en && st.cnt <= st.win && !sys_reset_req
            && wb_req.dat[`WWD_CNT_MSB:`WWD_CNT_LSB] > `WWD_CNT_UNDERFLOW
            |=> !sys_reset_req)
        else $error("Refresh inside the window requested a reset");

    a_window_load: assert property ( // see RULE_20
        s_config_write ##0 wb_req.sel[0]
            |=> st.win == $past(wb_req.dat[`WWD_WIN_MSB:`WWD_WIN_LSB]))
        else $error("Window value not loaded");

    a_prescale_load: assert property ( // see RULE_17
        s_config_write ##0 wb_req.sel[1:0] == 2'h3
            |=> st.prescale_select == $past(wb_req.dat[`WWD_PRS_MSB:`WWD_PRS_LSB]))
        else $error("Prescale select not loaded");

    a_ie_set: assert property ( // see RULE_18
        s_config_write ##0 wb_req.sel[1] && wb_req.dat[`WWD_IE_BIT] |=> st.ie)
        else $error("Interrupt enable not set by writing 1");

    a_config_read: assert property ( // see RULE_20
        s_bus_read(hit_config) |=> wb_dat_o[31:11] == 21'h000000
            && wb_dat_o[6:0] == $past(st.win) && wb_dat_o[9:7] == $past(st.prescale_select))
        else $error("Config read did not return its fields");

    a_count_read_en: assert property ( // see RULE_04
        s_bus_read(hit_count) |=> wb_dat_o[7] == $past(st.en) && wb_dat_o[31:8] == 24'h000000)
        else $error("Count read did not return the enable bit");

    a_unmapped_read: assert property ( // see RULE_16
        s_bus_read(!hit_count && !hit_config && !hit_status) |=> wb_dat_o == 32'h00000000)
        else $error("Unmapped read returned nonzero");

    // Settings must not move on a write to a hole in the map
    a_unmapped_write: assert property ( // see RULE_16
        wr && !hit_count && !hit_config && !hit_status
            |=> $stable(st.win) && $stable(st.prescale_select) && $stable(st.ie) && $stable(st.en))
        else $error("Unmapped write changed a setting");

    a_pov_hold: assert property ( // see RULE_19
        st.pre_overflow_flag && !(wr && hit_status && wb_req.sel[0] && !wb_req.dat[`WWD_POV_BIT])
            |=> st.pre_overflow_flag)
        else $error("Flag dropped without a clear");

    a_pov_source: assert property ( // see RULE_08
        $rose(st.pre_overflow_flag) |-> st.cnt == `WWD_CNT_PREWARN)
        else $error("Flag set away from 0x40");

endmodule : wwd_watchdog
`default_nettype wire

//--- wwd_map.svh
// Purpose: Register map, field positions, reset values and counts of the window watchdog
// Assumes: Byte addressed 32-bit register words on a classic Wishbone slave
// Notes:   Definitions only
`ifndef WWD_MAP_SVH
`define WWD_MAP_SVH

// Register byte offsets
`define WWD_OFF_CTRL_COUNT   4'h0
`define WWD_OFF_CTRL_CONFIG  4'h4
`define WWD_OFF_STATUS       4'h8

// Control count register fields
`define WWD_EN_BIT           7
`define WWD_CNT_MSB          6
`define WWD_CNT_LSB          0

// Control config register fields
`define WWD_WIN_MSB          6
`define WWD_WIN_LSB          0
`define WWD_PRS_MSB          9
`define WWD_PRS_LSB          7
`define WWD_IE_BIT           10

// Status register fields
`define WWD_POV_BIT          0

// Reset values
`define WWD_RST_CTRL_COUNT   32'h0000007F
`define WWD_RST_CNT          7'h7F
`define WWD_RST_WIN          7'h7F
`define WWD_RST_PRS          3'h0

// Counter thresholds
`define WWD_CNT_PREWARN      7'h40
`define WWD_CNT_UNDERFLOW    7'h3F
`define WWD_CNT_ONE          7'h01

// Base division is two to this power; seven doublings above it
`define WWD_DIV_BASE_LOG2    12
`define WWD_DIV_LEVELS_LOG2  7

`endif

//--- wwd_pkg.sv
// Purpose: Types shared by the window watchdog files
// Assumes: Constants come from wwd_map.svh
// Notes:   Nothing is imported; users write wwd_pkg::name
package wwd_pkg;

    // Classic Wishbone request bundle from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wwd_wb_req_s;

    // Whole state of the watchdog core
    typedef struct packed {
        logic        en;
        logic [6:0]  cnt;
        logic [6:0]  win;
        logic [2:0]  prescale_select;
        logic        ie;
        logic        pre_overflow_flag;
        logic        rst_req;
        logic        ack;
        logic [31:0] rdata;
    } wwd_state_s;

endpackage : wwd_pkg

//--- wwd_prescaler.sv
// Purpose: Power-of-two prescaler making the count tick from mclk
// Assumes: sel steps the divider from 2**BASE_LOG2 up to 2**(BASE_LOG2+7)
// Notes:   Fraction is held, not cleared, while run is low
`include "wwd_map.svh"
`timescale 1ns/10ps
`default_nettype none

module wwd_prescaler #(
    parameter int unsigned BASE_LOG2 = `WWD_DIV_BASE_LOG2
) (
    input  wire logic       mclk,     // Bus clock
    input  wire logic       reset_n,  // Async reset, active low
    input  wire logic       run,      // Count enable
    input  wire logic [2:0] sel,      // Division select
    output logic            tick      // One-cycle count tick
);
    localparam int unsigned W = BASE_LOG2 + `WWD_DIV_LEVELS_LOG2;

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } wwd_psc_s;

    wwd_psc_s     st;
    wwd_psc_s     next_st;
    logic [W-1:0] last;

    // Ones in the low BASE_LOG2+sel bits
    assign last = {W{1'b1}} >> (3'd7 - sel); // see RULE_02

    always_comb begin
        next_st      = st;
        next_st.tick = 1'b0;
        if (run) begin
            // A shorter divide picked mid-count wraps at once
            if (st.cnt >= last) begin // see RULE_02
                next_st.cnt  = '0;
                next_st.tick = 1'b1;
            end else begin
                next_st.cnt = st.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick = st.tick;

    a_tick_single: assert property (@(posedge mclk) disable iff (!reset_n)
        tick |=> !tick) else $error("Prescaler tick lasted two cycles"); // see RULE_02
    a_tick_limit: assert property (@(posedge mclk) disable iff (!reset_n)
        run && st.cnt == last |=> tick) else $error("Prescaler missed its tick"); // see RULE_02

endmodule : wwd_prescaler
`default_nettype wire

//--- test_window_watchdog_timer.sv
// Purpose: Self-checking bench for the window watchdog over classic Wishbone
// Assumes: Divider base shortened to 2**2 so a count tick is 4 << prs cycles
// Notes:   Waits are bounded; the timeout counts as a mismatch
`timescale 1ns/10ps
`default_nettype none

module test_window_watchdog_timer;
    logic                 mclk;
    logic                 reset_n;
    wwd_pkg::wwd_wb_req_s wb_req;
    logic [31:0]          wb_dat_o;
    logic                 wb_ack_o;
    logic                 deep_sleep;
    logic                 pre_overflow_irq;
    logic                 sys_reset_req;
    logic [31:0]          rd;
    int                   mismatches;
    int                   total_checks;
    int                   cycles;
    int                   n;

    wwd_watchdog #(.BASE_DIV_LOG2(2)) wwd_watchdog_i (
        .mclk             (mclk),
        .reset_n          (reset_n),
        .wb_req           (wb_req),
        .wb_dat_o         (wb_dat_o),
        .wb_ack_o         (wb_ack_o),
        .deep_sleep       (deep_sleep),
        .pre_overflow_irq (pre_overflow_irq),
        .sys_reset_req    (sys_reset_req)
    );

    initial begin
        mclk = 1'b0;
        // Bus clock runs from time zero, before any setup access
        forever #20 mclk = ~mclk;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    // Ceiling is roughly ten times the expected run
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches = mismatches + 1;
            end_sim();
        end
    end

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp, input string what);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask : chk_bit

    // One classic cycle; request held until ack is sampled high
    task automatic bus(input logic we, input logic [3:0] adr, input logic [31:0] wd);
        @(posedge mclk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wd};
        for (int i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (wb_ack_o === 1'b1) break;
        end
        if (wb_ack_o !== 1'b1) chk_bit(wb_ack_o, 1'b1, "no ack");
        rd = wb_dat_o;
        wb_req <= '0;
    endtask : bus

    task automatic wr(input logic [3:0] adr, input logic [31:0] wd);
        bus(1'b1, adr, wd);
        @(negedge mclk);
    endtask : wr

    task automatic do_reset;
        @(posedge mclk);
        reset_n <= 1'b0;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
    endtask : do_reset

    initial begin
        reset_n = 1'b0;
        wb_req = '0;
        deep_sleep = 1'b0;
        mismatches = 0;
        total_checks = 0;
        cycles = 0;
        do_reset();
        bus(1'b0, 4'h0, '0); chk_word(rd, 32'h0000007F, "count reset");
        bus(1'b0, 4'h4, '0); chk_word(rd, 32'h0000007F, "config reset");
        bus(1'b0, 4'h8, '0); chk_word(rd, 32'h00000000, "status reset");
        bus(1'b0, 4'hC, '0); chk_word(rd, 32'h00000000, "unmapped read");
        wr(4'h4, 32'h00000450);
        wr(4'h4, 32'h00000050);
        bus(1'b0, 4'h4, '0); chk_word(rd, 32'h00000450, "ie sticky");
        wr(4'h0, 32'h00000060);
        bus(1'b0, 4'h0, '0); chk_word(rd, 32'h00000060, "count load");
        wr(4'h0, 32'h000000E0);
        bus(1'b0, 4'h0, '0); chk_word(rd & 32'h80, 32'h80, "enable set");
        // Frozen count while asleep
        deep_sleep <= 1'b1;
        bus(1'b0, 4'h0, '0);
        n = rd;
        repeat (60) @(posedge mclk);
        bus(1'b0, 4'h0, '0); chk_word(rd, n, "sleep freeze");
        deep_sleep <= 1'b0;
        for (int i = 0; i < 100 && rd[6:0] > 7'h50; i++) bus(1'b0, 4'h0, '0);
        wr(4'h0, 32'h00000060);
        chk_bit(sys_reset_req, 1'b0, "refresh in window");
        bus(1'b0, 4'h0, '0); chk_bit(rd[7], 1'b1, "disable ignored");
        chk_bit(rd[6:0] > 7'h5D, 1'b1, "refresh reloads");
        for (int i = 0; i < 100 && rd[0] !== 1'b1; i++) bus(1'b0, 4'h8, '0);
        chk_bit(pre_overflow_irq, 1'b1, "irq on flag");
        wr(4'h8, 32'h00000000);
        chk_bit(pre_overflow_irq, 1'b0, "flag cleared");
        for (int i = 0; i < 600 && sys_reset_req !== 1'b1; i++) @(negedge mclk);
        chk_bit(sys_reset_req, 1'b1, "underflow reset");
        bus(1'b0, 4'h0, '0); chk_word(rd & 32'h7F, 32'h3F, "stop at 3F");
        $display("test window run done");
        do_reset();
        wr(4'h4, 32'h00000050);
        wr(4'h0, 32'h000000E0);
        chk_bit(sys_reset_req, 1'b0, "start ok");
        wr(4'h0, 32'h000000E0);
        chk_bit(sys_reset_req, 1'b1, "early refresh");
        do_reset();
        wr(4'h0, 32'h00000040);
        chk_bit(sys_reset_req, 1'b0, "load 40 ok");
        wr(4'h0, 32'h0000003F);
        chk_bit(sys_reset_req, 1'b1, "load 3F");
        $display("test illegal loads done");
        // Three ticks then half a tick at every prescale code
        for (int p = 0; p < 8; p++) begin
            do_reset();
            n = 4 << p;
            wr(4'h4, 32'h0000007E | (p << 7));
            bus(1'b0, 4'h4, '0); chk_word(rd, 32'h7E | (p << 7), "prescale field");
            wr(4'h0, 32'h000000FF);
            repeat (n * 3 + n / 2 - 2) @(posedge mclk);
            bus(1'b0, 4'h0, '0); chk_word(rd, 32'h000000FC, "tick rate");
        end
        $display("test prescaler done");
        end_sim();
    end
endmodule : test_window_watchdog_timer

`default_nettype wire
